// ### smbt_defs.svh
// Shared constants of the indexed block SMBus target
`ifndef SMBT_DEFS_SVH
`define SMBT_DEFS_SVH

// ----------------------------------------------------------------
// Strap decode: each tri-level strap arrives as a two-bit code
// ----------------------------------------------------------------
`define SMBT_TRI_LOW   2'h0
`define SMBT_TRI_MID   2'h1
`define SMBT_TRI_HIGH  2'h2

// Write form of the address per strap pair {strap1, strap0}
`define SMBT_ADDR_LL   8'hD8
`define SMBT_ADDR_LM   8'hDA
`define SMBT_ADDR_LH   8'hDE
`define SMBT_ADDR_ML   8'hC2
`define SMBT_ADDR_MM   8'hC4
`define SMBT_ADDR_MH   8'hC6
`define SMBT_ADDR_HL   8'hCA
`define SMBT_ADDR_HM   8'hCC
`define SMBT_ADDR_HH   8'hCE

// ----------------------------------------------------------------
// Byte count setting and timing
// ----------------------------------------------------------------
`define SMBT_BC_INDEX  8'h07
`define SMBT_BC_RST    5'h08
`define SMBT_CLK_NS    4
`define SMBT_REF_TMO_NS 256
`define SMBT_REF_TMO_CYC (`SMBT_REF_TMO_NS / `SMBT_CLK_NS)

`endif

// ### smbt_pkg.sv
// Types of the indexed block SMBus target
package smbt_pkg;

  // Bus engine states, Gray coded along address, ack, receive, send
  typedef enum logic [2:0] {
    SMBT_IDLE = 3'h0,
    SMBT_ADDR = 3'h1,
    SMBT_ACK  = 3'h3,
    SMBT_RX   = 3'h2,
    SMBT_TX   = 3'h6,
    SMBT_RACK = 3'h7
  } smbt_state_t;

endpackage

// ### smbt_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module smbt_fifo #(
  parameter int W = 13,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(D);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [W-1:0] mem_q [D];
  logic [PW:0]  wr_ff;
  logic [PW:0]  rd_ff;
  logic         push;
  logic         pop;

  if (D < 2 || (1 << PW) != D) begin : g_bad_depth
    $error("smbt_fifo depth must be a power of two of at least 2");
  end

  // Extra pointer bit tells full from empty
  assign in_ready  = !((wr_ff[PW] != rd_ff[PW]) && (wr_ff[PW-1:0] == rd_ff[PW-1:0]));
  assign out_valid = (wr_ff != rd_ff);
  assign out_data  = mem_q[rd_ff[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Write side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ff <= '0;
    end else if (push) begin
      wr_ff <= wr_ff + 1'b1;
    end
  end

  // Storage needs no reset, the pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ff[PW-1:0]] <= in_data;
    end
  end

  // Read side
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ff <= '0;
    end else if (pop) begin
      rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule

// ### smbt_regmem.sv
// Configuration byte memory with registered read data
`timescale 1ns/1ns
module smbt_regmem #(
  parameter int AW = 5
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic [7:0]         rd_data
);
  logic [7:0] mem_q [2**AW];

  // Write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read port, data one edge after the request
  always_ff @(posedge clk) begin
    if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// ### smbt_target.sv
// SMBus target with indexed block write and block read of config bytes
//
// How it works
// - Two tri-level straps pick one of nine write addresses.
// - Block write opens with start and write address; device acknowledges.
// - Host sends starting index next; device acknowledges it.
// - Host sends the data byte count; device acknowledges it.
// - Data for consecutive indices, each acknowledged; host ends with stop.
// - Block read sets index, repeated start, read address acknowledged.
// - Device first returns the number of bytes it will send.
// - Device returns consecutive bytes; host acknowledges all but the last.
// - Writable byte count sets read length; reset value eight gives nine bytes.
// - Interface answers only while the reference clock runs.
`timescale 1ns/1ns
`include "smbt_defs.svh"
module smbt_target #(
  parameter int AW    = 5,
  parameter int DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ref_clk,
  input  wire logic       smb_clk_i,
  output logic            smb_clk_o,
  output logic            smb_clk_oe,
  input  wire logic       smb_dat_i,
  output logic            smb_dat_o,
  output logic            smb_dat_oe,
  input  wire logic [3:0] address_strap_pins,
  output logic            smb_active
);
  localparam int FW = AW + 8;
  localparam int TMO = `SMBT_REF_TMO_CYC;

  if (AW < 4 || AW > 8) begin : g_bad_aw
    $error("smbt_target index width must be 4 to 8 bits");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Strap pair to write address; an illegal code falls back to low
  function automatic logic [7:0] addr_lookup(input logic [3:0] straps);
    logic [7:0] a;
    a = `SMBT_ADDR_LL;
    unique case (straps)
      {`SMBT_TRI_LOW, `SMBT_TRI_LOW}:   a = `SMBT_ADDR_LL;
      {`SMBT_TRI_LOW, `SMBT_TRI_MID}:   a = `SMBT_ADDR_LM;
      {`SMBT_TRI_LOW, `SMBT_TRI_HIGH}:  a = `SMBT_ADDR_LH;
      {`SMBT_TRI_MID, `SMBT_TRI_LOW}:   a = `SMBT_ADDR_ML;
      {`SMBT_TRI_MID, `SMBT_TRI_MID}:   a = `SMBT_ADDR_MM;
      {`SMBT_TRI_MID, `SMBT_TRI_HIGH}:  a = `SMBT_ADDR_MH;
      {`SMBT_TRI_HIGH, `SMBT_TRI_LOW}:  a = `SMBT_ADDR_HL;
      {`SMBT_TRI_HIGH, `SMBT_TRI_MID}:  a = `SMBT_ADDR_HM;
      {`SMBT_TRI_HIGH, `SMBT_TRI_HIGH}: a = `SMBT_ADDR_HH;
      default:                          a = `SMBT_ADDR_LL;
    endcase
    return a;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  smbt_pkg::smbt_state_t state_ff;
  logic [5:0]    in_s1_ff;
  logic [5:0]    in_s2_ff;
  logic [1:0]    in_s3_ff;
  logic          ref_tog_ff;
  logic          ref_s1_ff;
  logic          ref_s2_ff;
  logic          ref_s3_ff;
  logic [6:0]    wdog_ff;
  logic          alive_ff;
  logic [7:0]    own_addr_ff;
  logic [3:0]    bit_ff;
  logic [7:0]    sh_ff;
  logic          rw_ff;
  logic [1:0]    phase_ff;
  logic [AW-1:0] ptr_ff;
  logic [4:0]    bc_ff;
  logic          sda_oe_ff;
  logic          scl_oe_ff;
  logic          low_ff;
  logic          scl;
  logic          sda;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_ev;
  logic          stop_ev;
  logic [3:0]    strap_s;
  logic [AW-1:0] idx_in;
  logic [7:0]    cnt_byte;
  logic [7:0]    rd_data;
  logic [7:0]    data_byte;
  logic          rd_en;
  logic          push;
  logic          fifo_ready;
  logic [FW-1:0] drain_word;
  logic          drain_valid;
  logic          drain;
  logic [AW-1:0] drain_idx;
  logic [7:0]    drain_dat;

  // ----------------------------------------------------------------
  // Reference clock domain
  // ----------------------------------------------------------------
  // Toggle on every rising reference edge; only the toggle crosses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_tog_ff <= 1'b0;
    end else begin
      ref_tog_ff <= !ref_tog_ff;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Pins and the reference toggle pass two flops before any logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_s1_ff  <= 6'h3F;
      in_s2_ff  <= 6'h3F;
      in_s3_ff  <= 2'h3;
      ref_s1_ff <= 1'b0;
      ref_s2_ff <= 1'b0;
      ref_s3_ff <= 1'b0;
    end else begin
      in_s1_ff  <= {address_strap_pins, smb_dat_i, smb_clk_i};
      in_s2_ff  <= in_s1_ff;
      in_s3_ff  <= in_s2_ff[1:0];
      ref_s1_ff <= ref_tog_ff;
      ref_s2_ff <= ref_s1_ff;
      ref_s3_ff <= ref_s2_ff;
    end
  end

  assign scl      = in_s2_ff[0];
  assign sda      = in_s2_ff[1];
  assign strap_s  = in_s2_ff[5:2];
  assign scl_rise = scl && !in_s3_ff[0];
  assign scl_fall = !scl && in_s3_ff[0];
  // Start and stop are data edges while the clock stays high
  assign start_ev = scl && in_s3_ff[0] && in_s3_ff[1] && !sda;
  assign stop_ev  = scl && in_s3_ff[0] && !in_s3_ff[1] && sda;

  // ----------------------------------------------------------------
  // Reference clock watchdog
  // ----------------------------------------------------------------
  // A stalled reference shuts the bus engine off within TMO cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdog_ff  <= 7'(TMO); // Deaf until a reference edge is seen
      alive_ff <= 1'b0;
    end else begin
      if (ref_s2_ff != ref_s3_ff) begin
        wdog_ff <= '0;
      end else if (wdog_ff != 7'(TMO)) begin
        wdog_ff <= wdog_ff + 1'b1;
      end
      alive_ff <= (wdog_ff != 7'(TMO));
    end
  end

  // Address follows the straps; they are pins and settle long before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      own_addr_ff <= `SMBT_ADDR_LL;
    end else begin
      own_addr_ff <= addr_lookup(strap_s);
    end
  end

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  assign idx_in    = sh_ff[AW-1:0];
  assign cnt_byte  = {2'h0, 6'(bc_ff + 5'h01)};
  assign data_byte = (8'(ptr_ff) == `SMBT_BC_INDEX) ? {3'h0, bc_ff} : rd_data;
  // Host data bytes go to the FIFO; a full FIFO stretches the clock
  assign push = alive_ff && !start_ev && !stop_ev && state_ff == smbt_pkg::SMBT_RX
             && phase_ff == 2'h2 && bit_ff == 4'h8 && (scl_fall || scl_oe_ff);
  // Prefetch: the next byte sits in rd_data long before the clock falls
  assign rd_en = rw_ff && (state_ff == smbt_pkg::SMBT_ACK || state_ff == smbt_pkg::SMBT_RACK);

  // Sequencing, shifting and line drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff  <= smbt_pkg::SMBT_IDLE;
      bit_ff    <= '0;
      sh_ff     <= '0;
      rw_ff     <= 1'b0;
      phase_ff  <= '0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else if (!alive_ff || stop_ev) begin
      state_ff  <= smbt_pkg::SMBT_IDLE;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else if (start_ev) begin
      state_ff  <= smbt_pkg::SMBT_ADDR;
      bit_ff    <= '0;
      sda_oe_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        smbt_pkg::SMBT_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        smbt_pkg::SMBT_ADDR: begin
          if (scl_rise && bit_ff != 4'h8) begin
            sh_ff  <= {sh_ff[6:0], sda};
            bit_ff <= bit_ff + 1'b1;
          end else if (scl_fall && bit_ff == 4'h8) begin
            if (sh_ff[7:1] == own_addr_ff[7:1]) begin
              state_ff  <= smbt_pkg::SMBT_ACK;
              sda_oe_ff <= 1'b1;
              rw_ff     <= sh_ff[0];
              phase_ff  <= '0;
            end else begin
              state_ff <= smbt_pkg::SMBT_IDLE;
            end
          end
        end
        smbt_pkg::SMBT_ACK: begin
          if (scl_fall) begin
            bit_ff <= '0;
            if (rw_ff) begin
              // First byte of a read is the count, then data
              state_ff  <= smbt_pkg::SMBT_TX;
              sh_ff     <= cnt_byte;
              sda_oe_ff <= !cnt_byte[7];
              bit_ff    <= 4'h1;
            end else begin
              state_ff  <= smbt_pkg::SMBT_RX;
              sda_oe_ff <= 1'b0;
            end
          end
        end
        smbt_pkg::SMBT_RX: begin
          if (scl_rise && bit_ff != 4'h8) begin
            sh_ff  <= {sh_ff[6:0], sda};
            bit_ff <= bit_ff + 1'b1;
          end else if (bit_ff == 4'h8 && (scl_fall || scl_oe_ff)) begin
            if (phase_ff == 2'h0) begin
              state_ff  <= smbt_pkg::SMBT_ACK;
              sda_oe_ff <= 1'b1;
              phase_ff  <= 2'h1;
            end else if (phase_ff == 2'h1) begin
              state_ff  <= smbt_pkg::SMBT_ACK;
              sda_oe_ff <= 1'b1;
              phase_ff  <= 2'h2;
            end else if (fifo_ready) begin
              state_ff  <= smbt_pkg::SMBT_ACK;
              sda_oe_ff <= 1'b1;
              scl_oe_ff <= 1'b0;
            end else begin
              scl_oe_ff <= 1'b1;
            end
          end
        end
        smbt_pkg::SMBT_TX: begin
          if (scl_fall) begin
            if (bit_ff == 4'h8) begin
              state_ff  <= smbt_pkg::SMBT_RACK;
              sda_oe_ff <= 1'b0;
            end else begin
              sh_ff     <= {sh_ff[6:0], 1'b0};
              sda_oe_ff <= !sh_ff[6];
              bit_ff    <= bit_ff + 1'b1;
            end
          end
        end
        smbt_pkg::SMBT_RACK: begin
          if (scl_rise && sda) begin
            state_ff <= smbt_pkg::SMBT_IDLE;
          end else if (scl_fall) begin
            state_ff  <= smbt_pkg::SMBT_TX;
            sh_ff     <= data_byte;
            sda_oe_ff <= !data_byte[7];
            bit_ff    <= 4'h1;
          end
        end
        default: begin
          state_ff  <= smbt_pkg::SMBT_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Byte pointer: loaded from the index, steps per data byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_ff <= '0;
    end else if (alive_ff && !start_ev && !stop_ev) begin
      if (state_ff == smbt_pkg::SMBT_RX && phase_ff == 2'h0 && bit_ff == 4'h8 && scl_fall) begin
        ptr_ff <= idx_in;
      end else if (push && fifo_ready) begin
        ptr_ff <= ptr_ff + 1'b1;
      end else if (state_ff == smbt_pkg::SMBT_RACK && scl_fall) begin
        ptr_ff <= ptr_ff + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write buffer and byte store
  // ----------------------------------------------------------------
  smbt_fifo #(
    .W (FW),
    .D (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   ({ptr_ff, sh_ff}),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .out_data  (drain_word),
    .out_valid (drain_valid),
    .out_ready (!rd_en)
  );

  // Drain stalls while a read is pending, so a read never races a write
  assign drain     = drain_valid && !rd_en;
  assign drain_idx = drain_word[FW-1:8];
  assign drain_dat = drain_word[7:0];

  smbt_regmem #(
    .AW (AW)
  ) u_mem (
    .clk     (clk),
    .wr_en   (drain),
    .wr_addr (drain_idx),
    .wr_data (drain_dat),
    .rd_en   (rd_en),
    .rd_addr (ptr_ff),
    .rd_data (rd_data)
  );

  // Byte count setting lives in flops so that it has a reset value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bc_ff <= `SMBT_BC_RST;
    end else if (drain && 8'(drain_idx) == `SMBT_BC_INDEX) begin
      bc_ff <= drain_dat[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open-drain lines only ever pull low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_ff <= 1'b0;
    end else begin
      low_ff <= 1'b0;
    end
  end

  assign smb_clk_o  = low_ff;
  assign smb_dat_o  = low_ff;
  assign smb_clk_oe = scl_oe_ff;
  assign smb_dat_oe = sda_oe_ff;
  assign smb_active = alive_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_quiet;
    alive_ff && !start_ev && !stop_ev;
  endsequence
  sequence s_addr_done;
    s_quiet ##0 state_ff == smbt_pkg::SMBT_ADDR && scl_fall && bit_ff == 4'h8;
  endsequence
  sequence s_rx_done;
    s_quiet ##0 state_ff == smbt_pkg::SMBT_RX && scl_fall && bit_ff == 4'h8;
  endsequence

  chk_addr_miss: assert property (s_addr_done ##0 sh_ff[7:1] != own_addr_ff[7:1]
    |=> state_ff == smbt_pkg::SMBT_IDLE && !sda_oe_ff) else $error("foreign address answered");
  chk_addr_ack: assert property (s_addr_done ##0 sh_ff[7:1] == own_addr_ff[7:1]
    |=> state_ff == smbt_pkg::SMBT_ACK && sda_oe_ff) else $error("own address not acked");
  chk_ack_hold: assert property (s_quiet ##0 state_ff == smbt_pkg::SMBT_ACK && !scl_fall
    |=> sda_oe_ff) else $error("ack released early");
  chk_index_load: assert property (s_rx_done ##0 phase_ff == 2'h0
    |=> ptr_ff == $past(idx_in) && sda_oe_ff) else $error("index not loaded");
  chk_count_ack: assert property (s_rx_done ##0 phase_ff == 2'h1
    |=> phase_ff == 2'h2 && sda_oe_ff) else $error("count byte not acked");
  chk_push_step: assert property (push && fifo_ready
    |=> ptr_ff == AW'($past(ptr_ff) + 1'b1) && sda_oe_ff) else $error("pointer did not step");
  chk_count_byte: assert property (s_quiet ##0 state_ff == smbt_pkg::SMBT_ACK && rw_ff
    && scl_fall |=> sh_ff == $past(cnt_byte)) else $error("count byte wrong");
  chk_nack_end: assert property (s_quiet ##0 state_ff == smbt_pkg::SMBT_RACK && scl_rise
    && sda |=> state_ff == smbt_pkg::SMBT_IDLE ##1 !sda_oe_ff) else $error("nack ignored");
  chk_bc_update: assert property (drain && 8'(drain_idx) == `SMBT_BC_INDEX
    |=> bc_ff == $past(drain_dat[4:0])) else $error("byte count not written");
  chk_ref_gate: assert property (!alive_ff
    |=> state_ff == smbt_pkg::SMBT_IDLE && !sda_oe_ff && !scl_oe_ff) else $error("answers w/o ref");
endmodule

// ### smbt_host_model.sv
// Behavioural SMBus host that runs block transfers on the wired lines
`timescale 1ns/1ns
module smbt_host_model #(
  parameter int QC = 62
) (
  input  wire logic  clk,
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       scl_oe,
  output logic       sda_oe,
  output logic       res_stb,
  output logic [7:0] res_val
);
  // ----------------------------------------------------------------
  // Line control, changed only at falling edges of clk
  // ----------------------------------------------------------------
  // Both lines released at time zero, so the pull-ups hold them high
  initial begin
    scl_oe  = 1'b0;
    sda_oe  = 1'b0;
    res_stb = 1'b0;
    res_val = 8'h00;
  end

  // Quarter bit: 62 cycles keeps each clock phase far above 3 clk
  task automatic qwait;
    repeat (QC) @(negedge clk);
  endtask

  // Bounded wait, since the device may stretch the clock low
  task automatic wait_high;
    int n;
    n = 0;
    while (!scl && n < 4000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // One bit; a one is sent by releasing data so the device may pull it
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    qwait();
    scl_oe = 1'b0;
    wait_high();
    qwait();
    r = sda;
    qwait();
    scl_oe = 1'b1;
    qwait();
  endtask

  // Hand one result to the bench monitor
  task automatic emit(input logic [7:0] v);
    res_val = v;
    res_stb = 1'b1;
    @(negedge clk);
    res_stb = 1'b0;
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start;
    sda_oe = 1'b0;
    qwait();
    scl_oe = 1'b0;
    wait_high();
    qwait();
    sda_oe = 1'b1;
    qwait();
    scl_oe = 1'b1;
    qwait();
  endtask

  // Stop: data rises while clock is high
  task automatic stop;
    sda_oe = 1'b1;
    qwait();
    scl_oe = 1'b0;
    wait_high();
    qwait();
    sda_oe = 1'b0;
    qwait();
  endtask

  // Byte out, MSB first; the acknowledge level seen is the result
  task automatic byte_out(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    emit({7'h00, r});
  endtask

  // Byte in; host acknowledges unless this is the last byte
  task automatic byte_in(input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(last, r);
    emit(v);
  endtask
endmodule

// ### tb_smbus_indexed_block_target.sv
// Self-checking bench of the indexed block SMBus target
`timescale 1ns/1ns
module tb_smbus_indexed_block_target;
  logic       clk;
  logic       rst;
  logic       ref_clk;
  logic       ref_run;
  logic       h_scl_oe;
  logic       h_sda_oe;
  logic       d_clk_oe;
  logic       d_dat_oe;
  logic       d_clk_o;
  logic       d_dat_o;
  logic       scl;
  logic       sda;
  logic [3:0] strap;
  logic       active;
  logic       res_stb;
  logic [7:0] res_val;
  logic [7:0] exp_q[$];
  logic [7:0] dev_addr;
  logic [7:0] rnd0;
  logic [7:0] rnd1;
  int         n_errors;
  int         total_checks;
  logic [7:0] addr_tab [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};

  // ----------------------------------------------------------------
  // Clocks, wired lines and instances
  // ----------------------------------------------------------------
  // System clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Reference clock, 64 ns, offset phase; stands still when stopped
  initial begin
    ref_clk = 1'b0;
    #7;
    forever begin
      #32;
      if (ref_run) ref_clk = ~ref_clk;
    end
  end

  // Open drain with pull-up: low if either party enables its driver
  assign scl = (h_scl_oe | d_clk_oe) ? 1'b0 : 1'b1;
  assign sda = (h_sda_oe | d_dat_oe) ? 1'b0 : 1'b1;

  smbt_target #(.AW(5), .DEPTH(16)) dut (
    .clk(clk), .rst(rst), .ref_clk(ref_clk), .smb_clk_i(scl), .smb_clk_o(d_clk_o),
    .smb_clk_oe(d_clk_oe), .smb_dat_i(sda), .smb_dat_o(d_dat_o), .smb_dat_oe(d_dat_oe),
    .address_strap_pins(strap), .smb_active(active));

  smbt_host_model #(.QC(62)) host (
    .clk(clk), .scl(scl), .sda(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe),
    .res_stb(res_stb), .res_val(res_val));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp=%h seen=%h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Note the expected acknowledge level (0 = acknowledged), then send
  task automatic wr(input logic [7:0] v, input logic a);
    exp_q.push_back({7'h00, a});
    host.byte_out(v);
  endtask

  // Note the expected byte, then receive it
  task automatic rd(input logic last, input logic [7:0] e);
    exp_q.push_back(e);
    host.byte_in(last);
  endtask

  // Each result from the host is matched to the oldest note
  always @(posedge res_stb) begin
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("MISMATCH result exp=none seen=%h", res_val);
    end else begin
      check("result", res_val, exp_q.pop_front());
    end
  end

  // Guard against a hang; the tests need roughly 70000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog exp=done seen=hang");
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ref_run = 1'b1;
    strap = 4'h0;
    dev_addr = 8'hCE;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'h88AFC1AC));
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (120) @(negedge clk);
    check("active", {7'h00, active}, 8'h01);
    // Every strap pair answers at its own address
    for (int s = 0; s < 9; s++) begin
      strap = {2'(s / 3), 2'(s % 3)};
      repeat (8) @(negedge clk);
      host.start();
      wr(addr_tab[s], 1'b0);
      host.stop();
    end
    $display("test address_sweep done");
    // Another strap's address is refused
    host.start();
    wr(8'hD8, 1'b1);
    host.stop();
    $display("test address_refuse done");
    // Default count byte: setting 8 gives nine bytes
    host.start();
    wr(dev_addr, 1'b0);
    wr(8'h00, 1'b0);
    host.start();
    wr(dev_addr | 8'h01, 1'b0);
    rd(1'b1, 8'h09);
    host.stop();
    $display("test default_count done");
    // Block write of random data, last byte rewrites the count
    rnd0 = 8'($urandom);
    rnd1 = 8'($urandom);
    host.start();
    wr(dev_addr, 1'b0);
    wr(8'h05, 1'b0);
    wr(8'h03, 1'b0);
    wr(rnd0, 1'b0);
    wr(rnd1, 1'b0);
    wr(8'h04, 1'b0);
    host.stop();
    // Read back from the same index with the new count
    host.start();
    wr(dev_addr, 1'b0);
    wr(8'h05, 1'b0);
    host.start();
    wr(dev_addr | 8'h01, 1'b0);
    rd(1'b0, 8'h05);
    rd(1'b0, rnd0);
    rd(1'b0, rnd1);
    rd(1'b1, 8'h04);
    host.stop();
    $display("test write_read done");
    // Stopped reference clock silences the interface
    ref_run = 1'b0;
    repeat (100) @(negedge clk);
    check("active", {7'h00, active}, 8'h00);
    // Without a reference the clock line driver must be off and the open-drain values low
    check("lines_idle", {5'h00, d_clk_oe, d_clk_o, d_dat_o}, 8'h00);
    host.start();
    wr(dev_addr, 1'b1);
    host.stop();
    ref_run = 1'b1;
    repeat (120) @(negedge clk);
    check("active", {7'h00, active}, 8'h01);
    $display("test ref_clock_stop done");
    summarize();
  end
endmodule
